/* bench/dpb_host_tb.sv */
// Self-checking bench for the two-port host controller.
// Assumes dpb_ram_model as the far side and pull-ups on both conflict nets.
`timescale 1ns/1ps
module dpb_host_tb;
    logic                     mclk, reset_n, slow;
    logic [1:0]               vld, wrq, inh, rdy, rv, rb, ce_n, we_n, oe_n, dq_oe, c_o, c_oe, net, pull;
    logic                     cerr;
    dpb_pkg::dpb_addr_t [1:0] ad, pa;
    dpb_pkg::dpb_data_t [1:0] wd, rd, dq_o, dqi, md;
    dpb_pkg::dpb_data_t       sb [0:1023] = '{default: 8'h00};
    logic [31:0]              seed = 32'h00009597;
    int                       failures = 0;
    int                       n_checks = 0;

    // --------------------------------
    // Design, partner and wiring
    // --------------------------------
    dpb_host i_dut
    (
        .mclk(mclk), .reset_n(reset_n), .conflict_error(cerr), .left_inhibit(inh[0]), .right_inhibit(inh[1]),
        .left_req_valid(vld[0]), .left_req_write(wrq[0]), .left_req_addr(ad[0]), .left_req_wdata(wd[0]),
        .left_req_ready(rdy[0]), .left_rsp_valid(rv[0]), .left_rsp_busy(rb[0]), .left_rsp_rdata(rd[0]),
        .right_req_valid(vld[1]), .right_req_write(wrq[1]), .right_req_addr(ad[1]), .right_req_wdata(wd[1]),
        .right_req_ready(rdy[1]), .right_rsp_valid(rv[1]), .right_rsp_busy(rb[1]), .right_rsp_rdata(rd[1]),
        .left_addr(pa[0]), .left_ce_n(ce_n[0]), .left_we_n(we_n[0]), .left_oe_n(oe_n[0]),
        .left_dq_o(dq_o[0]), .left_dq_oe(dq_oe[0]), .left_dq_i(dqi[0]),
        .right_addr(pa[1]), .right_ce_n(ce_n[1]), .right_we_n(we_n[1]), .right_oe_n(oe_n[1]),
        .right_dq_o(dq_o[1]), .right_dq_oe(dq_oe[1]), .right_dq_i(dqi[1]),
        .left_conflict_n_i(net[0]), .left_conflict_n_o(c_o[0]), .left_conflict_n_oe(c_oe[0]),
        .right_conflict_n_i(net[1]), .right_conflict_n_o(c_o[1]), .right_conflict_n_oe(c_oe[1])
    );
    // One arbiter decides for the whole array
    dpb_ram_model i_ram
    (
        .mclk(mclk), .slow(slow), .addr(pa), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .din(dqi), .net(net), .dout(md), .pull(pull)
    );
    assign net = ~(pull | (c_oe & ~c_o));
    assign dqi = {dq_oe[1] ? dq_o[1] : md[1], dq_oe[0] ? dq_o[0] : md[0]};

    // --------------------------------
    // Helpers
    // --------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input int p, input logic w, input dpb_pkg::dpb_addr_t a, input dpb_pkg::dpb_data_t d,
                       input logic eb);
        int n;
        @(posedge mclk);
        vld[p] <= 1'b1;
        wrq[p] <= w;
        ad[p] <= a;
        wd[p] <= d;
        n = 0;
        do @(negedge mclk); while (rdy[p] !== 1'b1 && ++n < 400);
        @(posedge mclk);
        vld[p] <= 1'b0;
        n = 0;
        do @(negedge mclk); while (rv[p] !== 1'b1 && ++n < 400);
        chk(rv[p], 1'b1);
        chk(rb[p], eb);
        if (!w && !eb)
            chk(rd[p], sb[a]);
        if (w && !eb)
            sb[a] = d;
        chk(cerr, 1'b0);
    endtask
    task results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // --------------------------------
    // Clock, watchdog and scenarios
    // --------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial
    begin
        #(20000 * 5);
        failures++;
        results();
    end
    initial
    begin : main
        logic [31:0] r;
        {vld, wrq, inh, ad, wd} = '0;
        slow = 1'b0;
        reset_n = 1'b0;
        repeat (9) @(posedge mclk);
        @(negedge mclk);
        chk({rdy, ce_n, we_n, c_oe}, 8'hfc);
        @(posedge mclk);
        reset_n <= 1'b1;
        repeat (12)
        begin
            r = xs();
            slow <= r[31];
            fork
                acc(0, r[30], {1'b0, r[8:0]}, r[23:16], 1'b0);
                acc(1, r[29], {1'b1, r[17:9]}, r[15:8], 1'b0);
            join
        end
        // Same location, right arrives later and waits
        fork
            acc(0, 1'b1, 10'h123, 8'h11, 1'b0);
            begin
                repeat (2) @(posedge mclk);
                acc(1, 1'b1, 10'h123, 8'h22, 1'b0);
            end
        join
        // Colliding reads flag the later port
        fork
            acc(0, 1'b0, 10'h123, 8'h00, 1'b0);
            begin
                repeat (2) @(posedge mclk);
                acc(1, 1'b0, 10'h123, 8'h00, 1'b1);
            end
        join
        // Inhibit raised during the write pulse drops the write
        for (int p = 0; p < 2; p++)
        begin
            fork
                acc(p, 1'b1, 10'h123, 8'h33, 1'b1);
                begin
                    do @(negedge mclk); while (we_n[p] !== 1'b0);
                    @(posedge mclk);
                    inh[p] <= 1'b1;
                end
            join
            @(posedge mclk);
            inh <= 2'b00;
            acc(p, 1'b0, 10'h123, 8'h00, 1'b0);
        end
        results();
    end
endmodule

/* bench/dpb_ram_model.sv */
// Behavioural two-port RAM with master conflict arbiter, sampled on mclk.
// Assumes the bench resolves the open-drain conflict nets and the data buses.
`timescale 1ns/1ps
module dpb_ram_model
(
    // Clock and pace
    input  wire logic                     mclk,
    input  wire logic                     slow,
    // Port pins, index 0 left, 1 right
    input  wire dpb_pkg::dpb_addr_t [1:0] addr,
    input  wire logic [1:0]               ce_n,
    input  wire logic [1:0]               we_n,
    input  wire logic [1:0]               oe_n,
    input  wire dpb_pkg::dpb_data_t [1:0] din,
    input  wire logic [1:0]               net,
    output dpb_pkg::dpb_data_t [1:0]      dout,
    output logic [1:0]                    pull
);
    dpb_pkg::dpb_data_t       mem [0:1023] = '{default: 8'h00};
    dpb_pkg::dpb_data_t [1:0] last = '0;
    dpb_pkg::dpb_data_t [1:0] d_q  = '0;
    dpb_pkg::dpb_addr_t [1:0] a_q  = '0;
    dpb_pkg::dpb_addr_t [1:0] a_w  = '0;
    int unsigned              t [2] = '{0, 0};
    int unsigned              age [2] = '{0, 0};
    int unsigned              cyc = 0;
    logic [1:0]               blk = 2'b00;
    logic [1:0]               we_q = 2'b11;
    logic                     match;
    initial pull = 2'b00;

    // --------------------------------
    // Arbitration on enable and address
    // --------------------------------
    assign match = !ce_n[0] && !ce_n[1] && addr[0] == addr[1];
    always @(posedge mclk)
    begin : arb
        int unsigned te [2];
        for (int i = 0; i < 2; i++)
        begin
            te[i] = (ce_n[i] || addr[i] != a_q[i]) ? cyc : t[i];
            t[i] <= te[i];
            a_q[i] <= addr[i];
        end
        cyc <= cyc + 1;
        if (!match)
            pull <= 2'b00;
        else if (pull == 2'b00)
            pull <= (te[1] < te[0]) ? 2'b01 : 2'b10;
    end

    // --------------------------------
    // Write path with inhibit, read path
    // --------------------------------
    always @(posedge mclk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            we_q[i] <= we_n[i];
            last[i] <= dout[i];
            age[i] <= (ce_n[i] || oe_n[i]) ? 0 : age[i] + 1;
            if (!we_n[i])
            begin
                d_q[i] <= din[i];
                a_w[i] <= addr[i];
                if (!net[i])
                    blk[i] <= 1'b1;
            end
            else if (!we_q[i])
            begin
                if (!blk[i])
                    mem[a_w[i]] <= d_q[i];
                blk[i] <= 1'b0;
            end
        end
    end
    always_comb
        for (int i = 0; i < 2; i++)
            dout[i] = (!ce_n[i] && !oe_n[i] && we_n[i] && (!slow || age[i] >= 3)) ? mem[addr[i]] : ~last[i];
endmodule

/* core/dpb_defines.svh */
// Timing constants and field widths for the dual-port conflict host controller.
// Assumes a 200 MHz mclk; included by bare name.
`ifndef DPB_DEFINES_SVH
`define DPB_DEFINES_SVH

`define DPB_ADDR_W        10
`define DPB_DATA_W        8
`define DPB_CLK_PERIOD_PS 5000
// Least time address and enable are held before the write pulse starts
`define DPB_RESOLVE_NS    20
`define DPB_RESOLVE_CYC   ((`DPB_RESOLVE_NS * 1000 + `DPB_CLK_PERIOD_PS - 1) / `DPB_CLK_PERIOD_PS)
// Least write pulse width
`define DPB_WPULSE_NS     20
`define DPB_WPULSE_CYC    ((`DPB_WPULSE_NS * 1000 + `DPB_CLK_PERIOD_PS - 1) / `DPB_CLK_PERIOD_PS)
// Read access time before data is sampled
`define DPB_ACCESS_NS     25
`define DPB_ACCESS_CYC    ((`DPB_ACCESS_NS * 1000 + `DPB_CLK_PERIOD_PS - 1) / `DPB_CLK_PERIOD_PS)
`define DPB_CNT_W         4
`define DPB_RESET_INHIBIT 1'b0

`endif

/* core/dpb_host.sv */
// Two-port host controller for a dual-port RAM array with a master conflict arbiter.
// Assumes external pull-ups on the shared conflict nets and pins synchronous to mclk.
`timescale 1ns/1ps
`include "dpb_defines.svh"

// Summary of operation
// - With both inhibit inputs held low, both ports operate normally.
// - Holding a port's inhibit high blocks all writes through that port; the host issues no new write strobe, but a pulse under way runs on and the RAM gates it.
// - Only one master decides conflicts for a width-expanded array, so the host never arbitrates itself.
// - Each port holds address and enable for the resolve time before starting its write pulse.
module dpb_host
(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // Left user port
    input  wire logic               left_req_valid,
    input  wire logic               left_req_write,
    input  wire dpb_pkg::dpb_addr_t left_req_addr,
    input  wire dpb_pkg::dpb_data_t left_req_wdata,
    output logic                    left_req_ready,
    output logic                    left_rsp_valid,
    output logic                    left_rsp_busy,
    output dpb_pkg::dpb_data_t      left_rsp_rdata,
    // Right user port
    input  wire logic               right_req_valid,
    input  wire logic               right_req_write,
    input  wire dpb_pkg::dpb_addr_t right_req_addr,
    input  wire dpb_pkg::dpb_data_t right_req_wdata,
    output logic                    right_req_ready,
    output logic                    right_rsp_valid,
    output logic                    right_rsp_busy,
    output dpb_pkg::dpb_data_t      right_rsp_rdata,
    // Write-inhibit control and conflict error flag
    input  wire logic               left_inhibit,
    input  wire logic               right_inhibit,
    output logic                    conflict_error,
    // Left RAM port pins
    output dpb_pkg::dpb_addr_t      left_addr,
    output logic                    left_ce_n,
    output logic                    left_we_n,
    output logic                    left_oe_n,
    output dpb_pkg::dpb_data_t      left_dq_o,
    output logic                    left_dq_oe,
    input  wire dpb_pkg::dpb_data_t left_dq_i,
    // Right RAM port pins
    output dpb_pkg::dpb_addr_t      right_addr,
    output logic                    right_ce_n,
    output logic                    right_we_n,
    output logic                    right_oe_n,
    output dpb_pkg::dpb_data_t      right_dq_o,
    output logic                    right_dq_oe,
    input  wire dpb_pkg::dpb_data_t right_dq_i,
    // Shared conflict nets (open drain)
    input  wire logic               left_conflict_n_i,
    output logic                    left_conflict_n_o,
    output logic                    left_conflict_n_oe,
    input  wire logic               right_conflict_n_i,
    output logic                    right_conflict_n_o,
    output logic                    right_conflict_n_oe
);
    logic left_inh_r;
    logic right_inh_r;
    logic left_seen_n;
    logic right_seen_n;

    // ------------------------------------------------------------
    // Inhibit drivers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            left_inh_r  <= `DPB_RESET_INHIBIT;
            right_inh_r <= `DPB_RESET_INHIBIT;
        end
        else
        begin
            left_inh_r  <= left_inhibit;
            right_inh_r <= right_inhibit;
        end
    end

    // Only pull low; released level comes from the pull-up
    assign left_conflict_n_o   = 1'b0;
    assign right_conflict_n_o  = 1'b0;
    assign left_conflict_n_oe  = left_inh_r;
    assign right_conflict_n_oe = right_inh_r;

    // Shared net read back for every port
    assign left_seen_n  = left_conflict_n_i;
    assign right_seen_n = right_conflict_n_i;

    // ------------------------------------------------------------
    // Conflict monitor
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            conflict_error <= 1'b0;
        else
            conflict_error <= !left_seen_n && !right_seen_n && !left_inh_r && !right_inh_r;
    end

    // ------------------------------------------------------------
    // Port sequencers
    // ------------------------------------------------------------
    // Each port stalls on its own flag only; the other proceeds
    dpb_port_seq u_left
    (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .req_valid  (left_req_valid),
        .req_write  (left_req_write),
        .req_addr   (left_req_addr),
        .req_wdata  (left_req_wdata),
        .req_ready  (left_req_ready),
        .rsp_valid  (left_rsp_valid),
        .rsp_busy   (left_rsp_busy),
        .rsp_rdata  (left_rsp_rdata),
        .ram_addr   (left_addr),
        .ram_ce_n   (left_ce_n),
        .ram_we_n   (left_we_n),
        .ram_oe_n   (left_oe_n),
        .ram_dq_o   (left_dq_o),
        .ram_dq_oe  (left_dq_oe),
        .ram_dq_i   (left_dq_i),
        .conflict_n (left_seen_n)
    );

    // Busy during a pulse reports a write the RAM gated
    dpb_port_seq u_right
    (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .req_valid  (right_req_valid),
        .req_write  (right_req_write),
        .req_addr   (right_req_addr),
        .req_wdata  (right_req_wdata),
        .req_ready  (right_req_ready),
        .rsp_valid  (right_rsp_valid),
        .rsp_busy   (right_rsp_busy),
        .rsp_rdata  (right_rsp_rdata),
        .ram_addr   (right_addr),
        .ram_ce_n   (right_ce_n),
        .ram_we_n   (right_we_n),
        .ram_oe_n   (right_oe_n),
        .ram_dq_o   (right_dq_o),
        .ram_dq_oe  (right_dq_oe),
        .ram_dq_i   (right_dq_i),
        .conflict_n (right_seen_n)
    );

    // Single decider: this host never computes a conflict itself

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_pull_only_low;
        @(posedge mclk) disable iff (!reset_n)
        left_conflict_n_oe |-> (left_conflict_n_o == 1'b0);
    endproperty
    a_pull_only_low: assert property (p_pull_only_low) else $error("conflict net driven high");
    property p_inhibit_follows;
        @(posedge mclk) disable iff (!reset_n)
        right_inhibit |=> right_conflict_n_oe;
    endproperty
    a_inhibit_follows: assert property (p_inhibit_follows) else $error("inhibit not driven");
    property p_release_follows;
        @(posedge mclk) disable iff (!reset_n)
        !left_inhibit |=> !left_conflict_n_oe;
    endproperty
    a_release_follows: assert property (p_release_follows) else $error("inhibit not released");
    property p_busy_no_left_pulse;
        @(posedge mclk) disable iff (!reset_n)
        ($fell(left_we_n)) |-> $past(left_seen_n);
    endproperty
    a_busy_no_left_pulse: assert property (p_busy_no_left_pulse) else $error("left pulse while busy");
    property p_busy_no_right_pulse;
        @(posedge mclk) disable iff (!reset_n)
        ($fell(right_we_n)) |-> $past(right_seen_n);
    endproperty
    a_busy_no_right_pulse: assert property (p_busy_no_right_pulse) else $error("right pulse while busy");
    sequence s_left_busy_answer;
        left_rsp_valid && left_rsp_busy;
    endsequence
    property p_left_gated_reported;
        @(posedge mclk) disable iff (!reset_n)
        (!left_we_n && !left_seen_n) |-> ##[1:5] s_left_busy_answer;
    endproperty
    a_left_gated_reported: assert property (p_left_gated_reported) else $error("gated write unreported");
    sequence s_right_busy_answer;
        right_rsp_valid && right_rsp_busy;
    endsequence
    property p_right_gated_reported;
        @(posedge mclk) disable iff (!reset_n)
        (!right_we_n && !right_seen_n) |-> ##[1:5] s_right_busy_answer;
    endproperty
    a_right_gated_reported: assert property (p_right_gated_reported) else $error("gated write unreported");
    property p_error_quiet;
        @(posedge mclk) disable iff (!reset_n)
        (left_seen_n || right_seen_n) |=> !conflict_error;
    endproperty
    a_error_quiet: assert property (p_error_quiet) else $error("conflict error without both nets low");
    property p_right_pull_only_low;
        @(posedge mclk) disable iff (!reset_n)
        right_conflict_n_oe |-> (right_conflict_n_o == 1'b0);
    endproperty
    a_right_pull_only_low: assert property (p_right_pull_only_low) else $error("right net driven high");
endmodule

/* core/dpb_pkg.sv */
// Types for the dual-port conflict host controller.
// Assumes dpb_defines.svh is on the include path.
`include "dpb_defines.svh"
package dpb_pkg;
    typedef enum {ST_IDLE, ST_SETUP, ST_WPULSE, ST_RWAIT, ST_STALL, ST_DONE} dpb_state_t;
    typedef logic [`DPB_ADDR_W-1:0] dpb_addr_t;
    typedef logic [`DPB_DATA_W-1:0] dpb_data_t;
    typedef logic [`DPB_CNT_W-1:0]  dpb_cnt_t;
endpackage

/* core/dpb_port_seq.sv */
// One host port sequencer: drives address, enable, write strobe and data of one RAM port.
// Assumes the conflict pin level is synchronous to mclk.
`timescale 1ns/1ps
`include "dpb_defines.svh"
module dpb_port_seq
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    // User request and response
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire dpb_pkg::dpb_addr_t req_addr,
    input  wire dpb_pkg::dpb_data_t req_wdata,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic                   rsp_busy,
    output dpb_pkg::dpb_data_t     rsp_rdata,
    // RAM port pins
    output dpb_pkg::dpb_addr_t     ram_addr,
    output logic                   ram_ce_n,
    output logic                   ram_we_n,
    output logic                   ram_oe_n,
    output dpb_pkg::dpb_data_t     ram_dq_o,
    output logic                   ram_dq_oe,
    input  wire dpb_pkg::dpb_data_t ram_dq_i,
    input  wire logic              conflict_n
);
    dpb_pkg::dpb_state_t state_r;
    dpb_pkg::dpb_cnt_t   cnt_r;
    logic                write_r;
    logic                saw_busy_r;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign req_ready = (state_r == dpb_pkg::ST_IDLE);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r    <= dpb_pkg::ST_IDLE;
            cnt_r      <= 4'h0;
            write_r    <= 1'b0;
            saw_busy_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                dpb_pkg::ST_IDLE:
                begin
                    saw_busy_r <= 1'b0;
                    if (req_valid)
                    begin
                        write_r <= req_write;
                        cnt_r   <= 4'h0;
                        state_r <= req_write ? dpb_pkg::ST_SETUP : dpb_pkg::ST_RWAIT;
                    end
                end
                dpb_pkg::ST_SETUP:
                begin
                    // Hold address and enable until the conflict flag has resolved
                    if (cnt_r == 4'((`DPB_RESOLVE_CYC) - 1))
                    begin
                        cnt_r <= 4'h0;
                        if (!conflict_n)
                            state_r <= dpb_pkg::ST_STALL;
                        else
                            state_r <= dpb_pkg::ST_WPULSE;
                    end
                    else
                        cnt_r <= cnt_r + 4'h1;
                end
                dpb_pkg::ST_WPULSE:
                begin
                    if (!conflict_n)
                        saw_busy_r <= 1'b1;
                    if (cnt_r == 4'((`DPB_WPULSE_CYC) - 1))
                        state_r <= dpb_pkg::ST_DONE;
                    else
                        cnt_r <= cnt_r + 4'h1;
                end
                dpb_pkg::ST_RWAIT:
                begin
                    if (!conflict_n)
                        saw_busy_r <= 1'b1;
                    if (cnt_r == 4'((`DPB_ACCESS_CYC) - 1))
                        state_r <= dpb_pkg::ST_DONE;
                    else
                        cnt_r <= cnt_r + 4'h1;
                end
                dpb_pkg::ST_STALL:
                begin
                    // Busy: stall the write until the other side is done
                    if (conflict_n)
                    begin
                        cnt_r   <= 4'h0;
                        state_r <= dpb_pkg::ST_SETUP;
                    end
                end
                default:
                    state_r <= dpb_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin and answer registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ram_addr  <= 10'h000;
            ram_dq_o  <= 8'h00;
            rsp_rdata <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_busy  <= 1'b0;
        end
        else
        begin
            rsp_valid <= (state_r == dpb_pkg::ST_DONE);
            rsp_busy  <= (state_r == dpb_pkg::ST_DONE) && saw_busy_r;
            if (state_r == dpb_pkg::ST_IDLE && req_valid)
            begin
                ram_addr <= req_addr;
                ram_dq_o <= req_wdata;
            end
            if (state_r == dpb_pkg::ST_RWAIT && cnt_r == 4'((`DPB_ACCESS_CYC) - 1))
                rsp_rdata <= ram_dq_i;
        end
    end

    assign ram_ce_n  = (state_r == dpb_pkg::ST_IDLE) || (state_r == dpb_pkg::ST_DONE);
    assign ram_we_n  = (state_r != dpb_pkg::ST_WPULSE);
    assign ram_oe_n  = (state_r != dpb_pkg::ST_RWAIT);
    assign ram_dq_oe = write_r && (state_r == dpb_pkg::ST_SETUP || state_r == dpb_pkg::ST_WPULSE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_setup_held;
        (state_r == dpb_pkg::ST_SETUP && !ram_ce_n && ram_we_n) [*4];
    endsequence
    property p_setup_before_pulse;
        @(posedge mclk) disable iff (!reset_n)
        ($rose(state_r == dpb_pkg::ST_SETUP)) |-> s_setup_held;
    endproperty
    a_setup_before_pulse: assert property (p_setup_before_pulse) else $error("write pulse before resolve time");
    property p_stall_no_strobe;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == dpb_pkg::ST_STALL) |-> (ram_we_n && !ram_ce_n);
    endproperty
    a_stall_no_strobe: assert property (p_stall_no_strobe) else $error("strobe while stalled on busy");
    property p_addr_stable;
        @(posedge mclk) disable iff (!reset_n)
        (!ram_ce_n && $past(!ram_ce_n)) |-> $stable(ram_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address changed during access");
endmodule
